// ### boot_strap_pkg.sv
package boot_strap_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] part_identity_addr  = 8'hc2;
  localparam int         id_family_lsb       = 4;
  // arbitrary neutral values
  localparam logic [3:0] id_family_code      = 4'h5;
  localparam logic [3:0] id_revision_code    = 4'h3;
  localparam logic [7:0] read_data_reset     = 8'h00;
  // edges after reset release before the synced strap level is valid
  localparam logic [1:0] strap_settle_count  = 2'h2;

  // ---------------------------------------------------------------
  // boot modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    boot_reset    = 3'b001,
    boot_normal   = 3'b010,
    boot_download = 3'b100
  } boot_mode_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_type;

endpackage : boot_strap_pkg

// ### boot_strap.sv
`timescale 1ns/1ps
module boot_strap
  import boot_strap_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire reg_req_type reg_req_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic        fetch_strobe_n_pin_in,
  input  wire logic        fetch_strobe_n_core_in,
  output logic             fetch_strobe_n_out,
  output logic             fetch_strobe_n_oe_out,
  input  wire logic        code_space_select_n_in,
  output logic             download_mode_out,
  output logic             normal_mode_out,
  output logic             external_fetch_out,
  output logic             emulation_link_out
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic          strobe_meta_r;
  logic          strobe_sync_r;
  logic          select_meta_r;
  logic          select_sync_r;
  boot_mode_type mode_r;

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strobe_meta_r <= 1'b1;
      strobe_sync_r <= 1'b1;
      select_meta_r <= 1'b1;
      select_sync_r <= 1'b1;
    end
    else
    begin
      strobe_meta_r <= fetch_strobe_n_pin_in;
      strobe_sync_r <= strobe_meta_r;
      select_meta_r <= code_space_select_n_in;
      select_sync_r <= select_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // the sync chain still shows its reset level for two edges after release,
  // so the strap is taken only once the chain carries the real pin level
  logic [1:0] settle_r;
  logic       strap_ready;

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      settle_r <= 2'h0;
    else if (settle_r != strap_settle_count)
      settle_r <= settle_r + 2'h1;
  end

  assign strap_ready = (settle_r == strap_settle_count);

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mode_r <= boot_reset;
    else
    begin
      case (mode_r)
        boot_reset:
          if (strap_ready)
            mode_r <= strobe_sync_r ? boot_normal : boot_download;
        boot_normal:
          mode_r <= boot_normal;
        boot_download:
          mode_r <= boot_download;
        default:
          mode_r <= boot_reset;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb
  begin
    fetch_strobe_n_oe_out = (mode_r != boot_reset);
    fetch_strobe_n_out    = fetch_strobe_n_core_in | (mode_r == boot_reset);
  end

  assign download_mode_out  = (mode_r == boot_download);
  assign normal_mode_out    = (mode_r == boot_normal);
  assign external_fetch_out = ~select_sync_r;
  assign emulation_link_out = select_sync_r;

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  function automatic logic [7:0] identity_value();
    identity_value = {id_family_code, id_revision_code};
  endfunction : identity_value

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= read_data_reset;
    else if (reg_req_in.rd && reg_req_in.addr == part_identity_addr)
      reg_rdata_out <= identity_value();
    else
      reg_rdata_out <= read_data_reset;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_id_read;
    @(posedge clock_in) disable iff (!rst_b_in)
    (reg_req_in.rd && reg_req_in.addr == part_identity_addr)
      |=> reg_rdata_out[7:id_family_lsb] == id_family_code;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read wrong");

  property p_id_const;
    @(posedge clock_in) disable iff (!rst_b_in)
    (reg_req_in.rd && reg_req_in.addr == part_identity_addr)
      |=> reg_rdata_out == {id_family_code, id_revision_code};
  endproperty
  a_id_const: assert property (p_id_const) else $error("identity value wrong");

  property p_unmapped_zero;
    @(posedge clock_in) disable iff (!rst_b_in)
    !(reg_req_in.rd && reg_req_in.addr == part_identity_addr) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("stray read data");

  property p_no_drive_in_reset;
    @(posedge clock_in) disable iff (!rst_b_in)
    (mode_r == boot_reset) |-> !fetch_strobe_n_oe_out;
  endproperty
  a_no_drive_in_reset: assert property (p_no_drive_in_reset) else $error("pin driven in strap");

  sequence s_strap_point;
    mode_r == boot_reset && strap_ready;
  endsequence

  property p_wait_settle;
    @(posedge clock_in) disable iff (!rst_b_in)
    (mode_r == boot_reset && !strap_ready) |=> mode_r == boot_reset;
  endproperty
  a_wait_settle: assert property (p_wait_settle) else $error("strap taken too early");

  property p_low_download;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_strap_point ##0 !strobe_sync_r) |=> download_mode_out && fetch_strobe_n_oe_out;
  endproperty
  a_low_download: assert property (p_low_download) else $error("no download entry");

  property p_high_normal;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_strap_point ##0 strobe_sync_r) |=> normal_mode_out && !download_mode_out;
  endproperty
  a_high_normal: assert property (p_high_normal) else $error("no normal entry");

  sequence s_decided;
    mode_r != boot_reset;
  endsequence

  property p_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_decided |=> $stable(mode_r);
  endproperty
  a_hold: assert property (p_hold) else $error("boot mode changed");

  property p_select;
    @(posedge clock_in) disable iff (!rst_b_in)
    strap_ready |-> external_fetch_out == !$past(code_space_select_n_in, 2);
  endproperty
  a_select: assert property (p_select) else $error("select decode wrong");

  property p_emulation;
    @(posedge clock_in) disable iff (!rst_b_in)
    strap_ready |-> emulation_link_out == $past(code_space_select_n_in, 2);
  endproperty
  a_emulation: assert property (p_emulation) else $error("emulation link wrong");

  property p_pin_follow;
    @(posedge clock_in) disable iff (!rst_b_in)
    fetch_strobe_n_oe_out |-> fetch_strobe_n_out == fetch_strobe_n_core_in;
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("strobe output wrong");

  property p_idle_high;
    @(posedge clock_in) disable iff (!rst_b_in)
    !fetch_strobe_n_oe_out |-> fetch_strobe_n_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("strobe low while released");

  property p_oe_decided;
    @(posedge clock_in) disable iff (!rst_b_in)
    fetch_strobe_n_oe_out == (download_mode_out || normal_mode_out);
  endproperty
  a_oe_decided: assert property (p_oe_decided) else $error("drive without a mode");

  property p_write_ignored;
    @(posedge clock_in) disable iff (!rst_b_in)
    (reg_req_in.wr && !reg_req_in.rd) |=> reg_rdata_out == read_data_reset;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed data");

  property p_settle_bound;
    @(posedge clock_in) disable iff (!rst_b_in)
    settle_r <= strap_settle_count;
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settle count overrun");

endmodule : boot_strap

// ### strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model
(
  input  wire logic dev_oe_in,
  input  wire logic dev_strobe_n_in,
  input  wire logic jumper_in,
  output logic      strobe_pin_out
);
  // pull-up on the pin; a fitted jumper pulls it low while the device is not driving
  assign strobe_pin_out = dev_oe_in ? dev_strobe_n_in : !jumper_in;
endmodule : strap_board_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import boot_strap_pkg::*;
  logic        clock_in, rst_b_in, core_n, sel_n, jumper, pin, oe, sout, dl, nm, ext, emu;
  reg_req_type req;
  logic [7:0]  rdata;
  int          err_total, compares, seed, i;
  boot_strap DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .fetch_strobe_n_pin_in(pin), .fetch_strobe_n_core_in(core_n),
    .fetch_strobe_n_out(sout), .fetch_strobe_n_oe_out(oe), .code_space_select_n_in(sel_n),
    .download_mode_out(dl), .normal_mode_out(nm), .external_fetch_out(ext),
    .emulation_link_out(emu));
  strap_board_model board (.dev_oe_in(oe), .dev_strobe_n_in(sout), .jumper_in(jumper),
    .strobe_pin_out(pin));
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  function automatic logic [7:0] id_exp(input logic [7:0] a);
    return (a == part_identity_addr) ? {id_family_code, id_revision_code} : 8'h00;
  endfunction : id_exp
  task automatic reg_cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req <= '{addr:a, wr:w, rd:!w, wdata:d};
    @(posedge clock_in);
    req <= '{default:'0};
    #1;
    check(rdata, w ? 8'h00 : id_exp(a));
    @(posedge clock_in);
    #1;
    check(rdata, 8'h00);
  endtask : reg_cycle
  task automatic boot(input logic j);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    jumper   <= j;
    repeat (16) @(posedge clock_in);
    #1;
    check({6'h0, oe, sout}, 8'h01);
    check({6'h0, dl, nm}, 8'h00);
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    check({6'h0, dl, nm}, j ? 8'h02 : 8'h01);
    check({7'h0, oe}, 8'h01);
    @(posedge clock_in);
    jumper <= !j;
    core_n <= 1'($random(seed));
    repeat (4) @(posedge clock_in);
    #1;
    check({6'h0, dl, nm}, j ? 8'h02 : 8'h01);
    check({7'h0, sout}, {7'h0, core_n});
  endtask : boot
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'hc4ae;
    rst_b_in = 1'b0;
    req = '{default:'0};
    core_n = 1'b1;
    sel_n = 1'b1;
    jumper = 1'b0;
    err_total = 0;
    compares = 0;
    for (i = 0; i < 8; i++)
    begin
      boot(i < 2 ? i[0] : 1'($random(seed)));
      @(posedge clock_in);
      sel_n <= 1'($random(seed));
      repeat (3) @(posedge clock_in);
      #1;
      check({6'h0, ext, emu}, {6'h0, !sel_n, sel_n});
      reg_cycle(1'b1, part_identity_addr, 8'($random(seed)));
      reg_cycle(1'b0, part_identity_addr, 8'h00);
      reg_cycle(1'b0, 8'($random(seed)), 8'h00);
      $display("test %0d done", i);
    end
    complete_run();
  end
  initial
  begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule : testbench
